// *** hw/csg_defs.svh ***
// Register map, field positions, reset values and timing of the conversion signal generators.
// Assumes a 32-bit AXI4-Lite slave with 12 byte-address bits and a 50 MHz aclk.
// Contract
// - Enable bit 8 switches the frame trigger generator off (0) or on (1).
// - Enabled frame generator pulses its count, starting at next associated clock rise.
// - Enable bit 1 stops (0) or runs (1) conversion clock B.
// - Enable bit 0 stops (0) or runs (1) conversion clock A.
// - All three enable bits read 0 after reset.
// - Enable bits act together, so generators enabled by one write start together.
// - Routing bits 5:4 drive frame trigger: 0x off, 10 rear, 11 front line 5.
// - Routing bits 3:2 drive clock B; code 0x keeps that driver off.
// - Each clock generator output runs at source frequency over divider plus one; the code always divides aclk, whatever source bits 30:29 hold.
// - Frame pulses are spaced interval plus one associated clock cycles apart.
// - A pulse count of zero makes frame pulses run until disabled.
// - Select bit 29 ties frame generator to clock A (0) or clock B (1).
`ifndef CSG_DEFS_SVH
`define CSG_DEFS_SVH
`define CSG_ADDR_W        12
`define CSG_OFS_CLK_A     12'h320
`define CSG_OFS_CLK_B     12'h324
`define CSG_OFS_FRAME_1   12'h32C
`define CSG_OFS_FRAME_2   12'h330
`define CSG_OFS_ENABLE    12'h33C
`define CSG_OFS_ROUTE     12'h340
`define CSG_OFS_STATUS    12'h348
`define CSG_DIV_W         28
`define CSG_DIV_RESET     28'hFFFFFFF
`define CSG_IVAL_RESET    28'hFFFFFFF
`define CSG_NUM_RESET     28'h0000000
`define CSG_SRC_LSB       29
`define CSG_FRAME_CLK_BIT 29
`define CSG_EN_A_BIT      0
`define CSG_EN_B_BIT      1
`define CSG_EN_FRAME_BIT  8
`define CSG_ROUTE_A_LSB   0
`define CSG_ROUTE_B_LSB   2
`define CSG_ROUTE_F_LSB   4
`define CSG_ROUTE_REAR    2'h2
`define CSG_ROUTE_FRONT   2'h3
`define CSG_RESP_OKAY     2'h0
`define CSG_RESP_SLVERR   2'h2
`endif

// *** hw/csg_pkg.sv ***
// Types shared by the conversion signal generator design.
// Assumes csg_defs.svh supplies the numeric constants.
package csg_pkg;
	typedef enum logic [3:0] {
		FRM_IDLE = 4'h1,
		FRM_WAIT = 4'h2,
		FRM_RUN  = 4'h4,
		FRM_DONE = 4'h8
	} csg_frame_e;
	typedef logic [27:0] csg_count_t;
endpackage

// *** hw/csg_clock_gen.sv ***
// One conversion clock generator: divides aclk by divider plus one.
// Assumes divider is stable while running; a change applies at once to the period in progress.
`include "csg_defs.svh"
module csg_clock_gen #(
	parameter int DIV_W = `CSG_DIV_W
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divider,
	output logic                  clk_out,
	output logic                  rise
);
	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic             run_q, out_d, rise_d;

	always_comb begin
		if (!run || !run_q) begin
			cnt_d = '0;
		end else if (cnt_q >= divider) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
		// High for the first half of each period; a divider of 0 holds it high
		out_d  = run && (cnt_d <= (divider >> 1));
		rise_d = run && (cnt_d == '0);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q   <= '0;
			run_q   <= 1'b0;
			clk_out <= 1'b0;
			rise    <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			run_q   <= run;
			clk_out <= out_d;
			rise    <= rise_d;
		end
	end
endmodule

// *** hw/csg_top.sv ***
// Conversion clock and frame trigger generators with enable and output routing registers.
// Assumes an AXI4-Lite master on aclk; pins are driven with active-low output enables.
`include "csg_defs.svh"
module csg_top #(
	parameter int DIV_W = `CSG_DIV_W
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [`CSG_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`CSG_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic                        rear_conv_clock_a,
	output logic                        rear_conv_clock_a_oe_n,
	output logic                        rear_conv_clock_b,
	output logic                        rear_conv_clock_b_oe_n,
	output logic                        rear_frame_trigger,
	output logic                        rear_frame_trigger_oe_n,
	output logic                        front_digital_line_1,
	output logic                        front_digital_line_1_oe_n,
	output logic                        front_digital_line_3,
	output logic                        front_digital_line_3_oe_n,
	output logic                        front_digital_line_5,
	output logic                        front_digital_line_5_oe_n
);
	// Register state
	logic [31:0]     clk_a_cfg_q, clk_a_cfg_d, clk_b_cfg_q, clk_b_cfg_d;
	logic [31:0]     frame_1_q, frame_1_d, frame_2_q, frame_2_d;
	logic [31:0]     enable_q, enable_d, route_q, route_d;
	// Bus state
	logic                   aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [`CSG_ADDR_W-1:0] waddr_q, waddr_d;
	logic [31:0]            wdata_q, wdata_d;
	logic [3:0]             wstrb_q, wstrb_d;
	logic                   bvalid_d, rvalid_d;
	logic [1:0]             bresp_d, rresp_d;
	logic [31:0]            rdata_d;
	// Generator state
	csg_pkg::csg_frame_e  frm_q, frm_d;
	csg_pkg::csg_count_t  ival_cnt_q, ival_cnt_d, pulses_q, pulses_d;
	logic                 pulse_q, pulse_d;
	logic                 clk_a, clk_b, rise_a, rise_b, rise_sel;
	logic                 do_write;

	function automatic logic mapped(input logic [`CSG_ADDR_W-1:0] a);
		mapped = (a == `CSG_OFS_CLK_A) || (a == `CSG_OFS_CLK_B) || (a == `CSG_OFS_FRAME_1)
			|| (a == `CSG_OFS_FRAME_2) || (a == `CSG_OFS_ENABLE) || (a == `CSG_OFS_ROUTE)
			|| (a == `CSG_OFS_STATUS);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] keep);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = m & keep;
	endfunction

	// Both generators see the same enable register edge, so one write starts them together
	csg_clock_gen #(.DIV_W(DIV_W)) u_clk_a (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (enable_q[`CSG_EN_A_BIT]),
		.divider (clk_a_cfg_q[DIV_W-1:0]),
		.clk_out (clk_a),
		.rise    (rise_a)
	);
	csg_clock_gen #(.DIV_W(DIV_W)) u_clk_b (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (enable_q[`CSG_EN_B_BIT]),
		.divider (clk_b_cfg_q[DIV_W-1:0]),
		.clk_out (clk_b),
		.rise    (rise_b)
	);

	assign rise_sel = frame_1_q[`CSG_FRAME_CLK_BIT] ? rise_b : rise_a;
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

	// Bus slave: address and data taken in either order, answered one cycle after both
	always_comb begin
		aw_held_d   = aw_held_q;
		w_held_d    = w_held_q;
		waddr_d     = waddr_q;
		wdata_d     = wdata_q;
		wstrb_d     = wstrb_q;
		bvalid_d    = s_axi_bvalid && !s_axi_bready;
		bresp_d     = s_axi_bresp;
		rvalid_d    = s_axi_rvalid && !s_axi_rready;
		rresp_d     = s_axi_rresp;
		rdata_d     = s_axi_rdata;
		clk_a_cfg_d = clk_a_cfg_q;
		clk_b_cfg_d = clk_b_cfg_q;
		frame_1_d   = frame_1_q;
		frame_2_d   = frame_2_q;
		enable_d    = enable_q;
		route_d     = route_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			waddr_d   = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = mapped(waddr_q) ? `CSG_RESP_OKAY : `CSG_RESP_SLVERR;
			if (waddr_q == `CSG_OFS_CLK_A) begin
				clk_a_cfg_d = merge(clk_a_cfg_q, wdata_q, wstrb_q, 32'h6FFFFFFF);
			end else if (waddr_q == `CSG_OFS_CLK_B) begin
				clk_b_cfg_d = merge(clk_b_cfg_q, wdata_q, wstrb_q, 32'h6FFFFFFF);
			end else if (waddr_q == `CSG_OFS_FRAME_1) begin
				frame_1_d = merge(frame_1_q, wdata_q, wstrb_q, 32'h2FFFFFFF);
			end else if (waddr_q == `CSG_OFS_FRAME_2) begin
				frame_2_d = merge(frame_2_q, wdata_q, wstrb_q, 32'h0FFFFFFF);
			end else if (waddr_q == `CSG_OFS_ENABLE) begin
				enable_d = merge(enable_q, wdata_q, wstrb_q, 32'h00000103);
			end else if (waddr_q == `CSG_OFS_ROUTE) begin
				route_d = merge(route_q, wdata_q, wstrb_q, 32'h0000003F);
			end
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = mapped(s_axi_araddr) ? `CSG_RESP_OKAY : `CSG_RESP_SLVERR;
			rdata_d  = 32'h00000000;
			if (s_axi_araddr == `CSG_OFS_CLK_A) begin
				rdata_d = clk_a_cfg_q;
			end else if (s_axi_araddr == `CSG_OFS_CLK_B) begin
				rdata_d = clk_b_cfg_q;
			end else if (s_axi_araddr == `CSG_OFS_FRAME_1) begin
				rdata_d = frame_1_q;
			end else if (s_axi_araddr == `CSG_OFS_FRAME_2) begin
				rdata_d = frame_2_q;
			end else if (s_axi_araddr == `CSG_OFS_ENABLE) begin
				rdata_d = enable_q;
			end else if (s_axi_araddr == `CSG_OFS_ROUTE) begin
				rdata_d = route_q;
			end else if (s_axi_araddr == `CSG_OFS_STATUS) begin
				rdata_d = {22'h000000, (frm_q == csg_pkg::FRM_DONE),
					(frm_q == csg_pkg::FRM_RUN) || (frm_q == csg_pkg::FRM_WAIT),
					6'h00, clk_b, clk_a};
			end
		end
	end

	// Frame trigger sequencer
	always_comb begin
		frm_d      = frm_q;
		ival_cnt_d = ival_cnt_q;
		pulses_d   = pulses_q;
		pulse_d    = 1'b0;
		case (frm_q)
			csg_pkg::FRM_IDLE: begin
				if (enable_q[`CSG_EN_FRAME_BIT]) begin
					frm_d = csg_pkg::FRM_WAIT;
				end
			end
			csg_pkg::FRM_WAIT: begin
				if (rise_sel) begin
					pulse_d    = 1'b1;
					pulses_d   = 28'h0000001;
					ival_cnt_d = '0;
					frm_d      = (frame_2_q[27:0] == 28'h0000001) ? csg_pkg::FRM_DONE
						: csg_pkg::FRM_RUN;
				end
			end
			csg_pkg::FRM_RUN: begin
				if (rise_sel) begin
					if (ival_cnt_q == frame_1_q[27:0]) begin
						pulse_d    = 1'b1;
						ival_cnt_d = '0;
						pulses_d   = pulses_q + 1'b1;
						if (frame_2_q[27:0] != '0 && pulses_d == frame_2_q[27:0]) begin
							frm_d = csg_pkg::FRM_DONE;
						end
					end else begin
						ival_cnt_d = ival_cnt_q + 1'b1;
					end
				end
			end
			csg_pkg::FRM_DONE: begin
				frm_d = csg_pkg::FRM_DONE;
			end
			default: begin
				frm_d = csg_pkg::FRM_IDLE;
			end
		endcase
		if (!enable_q[`CSG_EN_FRAME_BIT]) begin
			frm_d   = csg_pkg::FRM_IDLE;
			pulse_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			waddr_q      <= '0;
			wdata_q      <= 32'h00000000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CSG_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `CSG_RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			clk_a_cfg_q  <= {4'h0, `CSG_DIV_RESET};
			clk_b_cfg_q  <= {4'h0, `CSG_DIV_RESET};
			frame_1_q    <= {4'h0, `CSG_IVAL_RESET};
			frame_2_q    <= {4'h0, `CSG_NUM_RESET};
			enable_q     <= 32'h00000000;
			route_q      <= 32'h00000000;
			frm_q        <= csg_pkg::FRM_IDLE;
			ival_cnt_q   <= '0;
			pulses_q     <= '0;
			pulse_q      <= 1'b0;
		end else begin
			aw_held_q    <= aw_held_d;
			w_held_q     <= w_held_d;
			waddr_q      <= waddr_d;
			wdata_q      <= wdata_d;
			wstrb_q      <= wstrb_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp  <= bresp_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rresp  <= rresp_d;
			s_axi_rdata  <= rdata_d;
			// Ready only while nothing is held, so one write and one read are in flight
			s_axi_awready <= !aw_held_d && !bvalid_d && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held_d && !bvalid_d && !(s_axi_wvalid && s_axi_wready);
			s_axi_arready <= !rvalid_d && !(s_axi_arvalid && s_axi_arready);
			clk_a_cfg_q  <= clk_a_cfg_d;
			clk_b_cfg_q  <= clk_b_cfg_d;
			frame_1_q    <= frame_1_d;
			frame_2_q    <= frame_2_d;
			enable_q     <= enable_d;
			route_q      <= route_d;
			frm_q        <= frm_d;
			ival_cnt_q   <= ival_cnt_d;
			pulses_q     <= pulses_d;
			pulse_q      <= pulse_d;
		end
	end

	// Pin drivers; an undriven pin is held low with its enable released
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rear_conv_clock_a         <= 1'b0;
			rear_conv_clock_a_oe_n    <= 1'b1;
			front_digital_line_1      <= 1'b0;
			front_digital_line_1_oe_n <= 1'b1;
			rear_conv_clock_b         <= 1'b0;
			rear_conv_clock_b_oe_n    <= 1'b1;
			front_digital_line_3      <= 1'b0;
			front_digital_line_3_oe_n <= 1'b1;
			rear_frame_trigger        <= 1'b0;
			rear_frame_trigger_oe_n   <= 1'b1;
			front_digital_line_5      <= 1'b0;
			front_digital_line_5_oe_n <= 1'b1;
		end else begin
			rear_conv_clock_a_oe_n    <= route_q[1:0] != `CSG_ROUTE_REAR;
			rear_conv_clock_a         <= (route_q[1:0] == `CSG_ROUTE_REAR) && clk_a;
			front_digital_line_1_oe_n <= route_q[1:0] != `CSG_ROUTE_FRONT;
			front_digital_line_1      <= (route_q[1:0] == `CSG_ROUTE_FRONT) && clk_a;
			rear_conv_clock_b_oe_n    <= route_q[3:2] != `CSG_ROUTE_REAR;
			rear_conv_clock_b         <= (route_q[3:2] == `CSG_ROUTE_REAR) && clk_b;
			front_digital_line_3_oe_n <= route_q[3:2] != `CSG_ROUTE_FRONT;
			front_digital_line_3      <= (route_q[3:2] == `CSG_ROUTE_FRONT) && clk_b;
			rear_frame_trigger_oe_n   <= route_q[5:4] != `CSG_ROUTE_REAR;
			rear_frame_trigger        <= (route_q[5:4] == `CSG_ROUTE_REAR) && pulse_q;
			front_digital_line_5_oe_n <= route_q[5:4] != `CSG_ROUTE_FRONT;
			front_digital_line_5      <= (route_q[5:4] == `CSG_ROUTE_FRONT) && pulse_q;
		end
	end
endmodule

// *** test/csg_top_sva.sv ***
// Port-level checks of the conversion signal generator block.
// Assumes it is bound into csg_top and sees only that module's ports.
module csg_top_chk #(
	parameter int DIV_W = 28
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        rear_frame_trigger,
	input wire logic        rear_frame_trigger_oe_n,
	input wire logic        front_digital_line_5,
	input wire logic        front_digital_line_5_oe_n,
	input wire logic        rear_conv_clock_b,
	input wire logic        rear_conv_clock_b_oe_n,
	input wire logic        front_digital_line_3,
	input wire logic        front_digital_line_3_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	chk_reset_idle: assert property ($rose(aresetn) |-> rear_frame_trigger_oe_n
		&& front_digital_line_5_oe_n && !s_axi_bvalid && !s_axi_rvalid) else $error("not idle");
	chk_frame_rear_idle: assert property (rear_frame_trigger_oe_n |-> !rear_frame_trigger)
		else $error("released rear trigger pin shows data");
	chk_frame_front_idle: assert property (front_digital_line_5_oe_n |-> !front_digital_line_5)
		else $error("released front line 5 shows data");
	chk_clk_front_idle: assert property (front_digital_line_3_oe_n |-> !front_digital_line_3)
		else $error("released front line 3 shows data");
	chk_clk_rear_idle: assert property (rear_conv_clock_b_oe_n |-> !rear_conv_clock_b)
		else $error("released rear clock b pin shows data");
	chk_frame_one_pin: assert property (rear_frame_trigger_oe_n || front_digital_line_5_oe_n)
		else $error("frame trigger driven on two pins");
	chk_clk_b_one_pin: assert property (rear_conv_clock_b_oe_n || front_digital_line_3_oe_n)
		else $error("clock b driven on two pins");
endmodule
bind csg_top csg_top_chk #(.DIV_W(DIV_W)) chk_u (.*);

// *** test/csg_pin_load.sv ***
// Load on the generator pins: pull-downs, pulse counter and edge spacing meter.
// Assumes one clock and one frame route are enabled at a time.
module csg_pin_load (
	input wire logic aclk,
	input wire logic rear_conv_clock_a,
	input wire logic rear_conv_clock_a_oe_n,
	input wire logic front_digital_line_3,
	input wire logic front_digital_line_3_oe_n,
	input wire logic rear_frame_trigger,
	input wire logic rear_frame_trigger_oe_n,
	input wire logic front_digital_line_5,
	input wire logic front_digital_line_5_oe_n,
	output logic     w_clk_a,
	output logic     w_clk_b,
	output logic     w_frame,
	output int       frame_seen,
	output int       frame_gap,
	output int       clk_gap
);
	timeunit 1ns;
	timeprecision 1ps;
	bit pf, pc;
	int sf, sc;
	// Pull-downs: a released line reads 0, never the last driven value
	assign w_clk_a = !rear_conv_clock_a_oe_n & rear_conv_clock_a;
	assign w_clk_b = !front_digital_line_3_oe_n & front_digital_line_3;
	assign w_frame = (!rear_frame_trigger_oe_n & rear_frame_trigger)
		| (!front_digital_line_5_oe_n & front_digital_line_5);
	always @(posedge aclk) begin
		sf++;
		sc++;
		if (w_frame && !pf) begin
			frame_seen++;
			frame_gap = sf;
			sf = 0;
		end
		if ((w_clk_a || w_clk_b) && !pc) begin
			clk_gap = sc;
			sc = 0;
		end
		pf = w_frame;
		pc = w_clk_a || w_clk_b;
	end
endmodule

// *** test/csg_top_tb_top.sv ***
// Self-checking bench of the conversion signal generator block.
// Assumes csg_top, its checker bind and the pin load are compiled before it.
`include "csg_defs.svh"
module csg_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        rear_conv_clock_a, rear_conv_clock_a_oe_n, rear_conv_clock_b;
	logic        rear_conv_clock_b_oe_n, rear_frame_trigger, rear_frame_trigger_oe_n;
	logic        front_digital_line_1, front_digital_line_1_oe_n, front_digital_line_3;
	logic        front_digital_line_3_oe_n, front_digital_line_5, front_digital_line_5_oe_n;
	logic        w_clk_a, w_clk_b, w_frame;
	int          frame_seen, frame_gap, clk_gap, fails, compares, cyc, d, iv, n0;
	csg_top dut_u (.*);
	csg_pin_load load_u (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
			fails++;
		end
	endtask
	task automatic end_of_test;
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] dat);
		bit late;
		// A late bready makes the slave hold its response for a cycle
		late = ($urandom % 2) == 1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !late;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask
	task automatic rdr(input logic [11:0] a);
		bit late;
		// A late rready makes the slave hold its read data for a cycle
		late = ($urandom % 2) == 1;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !late;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		resp = s_axi_rresp;
		rd = s_axi_rdata;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test;
		end
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(32'h49BE06CE));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(`CSG_OFS_ENABLE);
		chk(rd, 32'h0);
		rdr(`CSG_OFS_ROUTE);
		chk(rd, 32'h0);
		rdr(12'h004);
		chk(32'(resp), 32'(`CSG_RESP_SLVERR));
		repeat (4) begin
			v = $urandom;
			wr(`CSG_OFS_ENABLE, v);
			rdr(`CSG_OFS_ENABLE);
			chk(rd, v & 32'h103);
		end
		wr(`CSG_OFS_ENABLE, 32'h0);
		// Only byte lane 1 written: just the frame enable may change
		s_axi_wstrb <= 4'h2;
		wr(`CSG_OFS_ENABLE, 32'hFFFFFFFF);
		s_axi_wstrb <= 4'hF;
		rdr(`CSG_OFS_ENABLE);
		chk(rd, 32'h100);
		wr(`CSG_OFS_ENABLE, 32'h0);
		for (int s = 0; s < 2; s++) begin
			d = 1 + $urandom % 3;
			iv = $urandom % 3;
			// Source bits left at 00 for both clocks
			wr(s ? `CSG_OFS_CLK_B : `CSG_OFS_CLK_A, d);
			wr(`CSG_OFS_FRAME_1, (s << 29) | iv);
			wr(`CSG_OFS_FRAME_2, 32'h3);
			wr(`CSG_OFS_ROUTE, s ? 32'h3C : 32'h22);
			n0 = frame_seen;
			wr(`CSG_OFS_ENABLE, 32'h100 | (1 << s));
			settle((4 * (iv + 1) + 2) * (d + 1) + 20);
			chk(frame_seen - n0, 3);
			chk(frame_gap, (iv + 1) * (d + 1));
			chk(clk_gap, d + 1);
			chk(s ? rear_conv_clock_b_oe_n : front_digital_line_3_oe_n, 1'b1);
			rdr(`CSG_OFS_STATUS);
			chk(rd & 32'h300, 32'h200);
			wr(`CSG_OFS_ENABLE, 32'h0);
		end
		wr(`CSG_OFS_FRAME_2, 32'h0);
		n0 = frame_seen;
		wr(`CSG_OFS_ENABLE, 32'h102);
		settle(6 * (iv + 1) * (d + 1) + 20);
		chk(frame_seen - n0 > 3, 1'b1);
		wr(`CSG_OFS_ENABLE, 32'h0);
		settle(4);
		n0 = frame_seen;
		settle(3 * (iv + 1) * (d + 1) + 10);
		chk(frame_seen - n0, 0);
		chk(w_clk_b, 1'b0);
		// Same source, equal rates, one enable write: the two clocks rise together
		wr(`CSG_OFS_CLK_A, 32'h1);
		wr(`CSG_OFS_CLK_B, 32'h1);
		wr(`CSG_OFS_ROUTE, 32'h0B);
		wr(`CSG_OFS_ENABLE, 32'h3);
		settle(4);
		n0 = 0;
		iv = 0;
		repeat (8) begin
			n0 += front_digital_line_1;
			iv += front_digital_line_1 && rear_conv_clock_b;
			@(negedge aclk);
		end
		chk(n0, 4);
		chk(iv, 4);
		chk({rear_conv_clock_a_oe_n, front_digital_line_1_oe_n, rear_conv_clock_b_oe_n,
			front_digital_line_3_oe_n, rear_frame_trigger_oe_n, front_digital_line_5_oe_n},
			6'h27);
		wr(12'h008, 32'hFFFF);
		chk(32'(resp), 32'(`CSG_RESP_SLVERR));
		end_of_test;
	end
endmodule
